// ==== dv/csd_crc_ref.svh ====
/*
 * bench-side reference check value, serial form of the generator.
 * assumes callers hand symbol bits 0..18 with bit 0 in the msb.
 */
`ifndef CSD_CRC_REF_SVH
`define CSD_CRC_REF_SVH
// serial shift: preset ones, then 19 data bits, then one zero bit
function automatic logic [4:0] csd_crc_ref(input logic [18:0] d);
	logic [4:0] c;
	logic fb;
	c = 5'h1F;
	for (int i = 18; i >= -1; i--) begin
		fb = c[4] ^ ((i >= 0) ? d[i] : 1'h0);
		c = {c[3:0], 1'h0} ^ (fb ? 5'h15 : 5'h00);
	end
	return c;
endfunction
`endif

// ==== dv/csd_monitor.sv ====
/*
 * checker on the codec ports: decode, encode and check value.
 * assumes one clock domain; attached by the bind at the foot.
 */
`include "csd_crc_ref.svh"
`default_nettype none
module csd_monitor (
	input wire logic mclk, // clock
	input wire logic reset, // async high
	input wire logic tx_req_valid, // offer
	input wire logic tx_req_ready, // taken
	input wire logic [23:0] tx_symbol, // sent word
	input wire logic tx_symbol_valid, // sent pulse
	input wire logic [23:0] rx_symbol, // received word
	input wire logic rx_symbol_valid, // received pulse
	input wire logic rx_sop, // start
	input wire logic rx_eop, // end
	input wire logic rx_cancel, // cancel
	input wire logic rx_restart_retry, // retry
	input wire logic rx_mcast, // event
	input wire logic rx_crc_err, // bad check
	input wire logic rx_reserved, // reserved
	input wire logic flush_req, // flush
	input wire logic dev_reset_req // reset confirm
);
	// ----------------------------------------
	// word classification
	// ----------------------------------------
	// a bad word must leave no trace but the error flag
	wire logic good;
	wire logic bad;
	wire logic [2:0] dl;
	assign good = rx_symbol_valid && (rx_symbol[4:0] == csd_crc_ref(rx_symbol[23:5]));
	assign bad = rx_symbol_valid && (rx_symbol[4:0] != csd_crc_ref(rx_symbol[23:5]));
	assign dl = rx_symbol[10:8];
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	crc_flag_a: assert property (bad |=> rx_crc_err)
		else $error("bad check not flagged");
	crc_quiet_a: assert property (bad |=> !(rx_sop || rx_eop || rx_cancel || rx_mcast ||
		rx_restart_retry)) else $error("bad word acted on");
	sop_decode_a: assert property (good && dl == 3'h0 |=> rx_sop && !rx_crc_err)
		else $error("start not decoded");
	retry_decode_a: assert property (good && dl == 3'h3 |=> rx_restart_retry)
		else $error("retry restart not decoded");
	mcast_decode_a: assert property (good && dl == 3'h5 |=> rx_mcast && !rx_cancel)
		else $error("event wrongly decoded");
	nop_ignore_a: assert property (good && dl == 3'h7 |=> !(rx_sop || rx_eop || rx_cancel ||
		rx_mcast || rx_reserved)) else $error("no-op half acted on");
	tx_check_a: assert property (tx_symbol_valid |->
		tx_symbol[4:0] == csd_crc_ref(tx_symbol[23:5])) else $error("sent check wrong");
	tx_mod_a: assert property (tx_symbol_valid && tx_symbol[10:8] != 3'h4 |->
		tx_symbol[7:5] == 3'h0) else $error("modifier not zero");
	tx_take_a: assert property (tx_req_valid && tx_req_ready |=> tx_symbol_valid)
		else $error("taken symbol not sent");
	cover property (dev_reset_req);
	cover property (flush_req);
	cover property (rx_cancel && rx_restart_retry);
endmodule
bind csd_codec csd_monitor u_mon (.mclk, .reset, .tx_req_valid, .tx_req_ready, .tx_symbol,
	.tx_symbol_valid, .rx_symbol, .rx_symbol_valid, .rx_sop, .rx_eop, .rx_cancel,
	.rx_restart_retry, .rx_mcast, .rx_crc_err, .rx_reserved, .flush_req, .dev_reset_req);
`default_nettype wire

// ==== dv/csd_peer.sv ====
/*
 * far port model: sends checked symbols and answers output flushes.
 * assumes send is called just after a rising edge.
 */
`include "csd_crc_ref.svh"
`default_nettype none
module csd_peer (
	input wire logic mclk, // clock
	input wire logic flush_req, // flush asked
	input wire logic [3:0] flush_lag, // extra flush cycles
	output logic flush_done, // flush finished
	output logic [23:0] rx_symbol, // word to the codec
	output logic rx_symbol_valid // word pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] lag_cnt;
	initial begin
		flush_done = 1'h0;
		rx_symbol = 24'h5A5A5A;
		rx_symbol_valid = 1'h0;
		lag_cnt = 4'h0;
	end
	// idle word keeps toggling so no stale value can pass for a symbol
	always @(posedge mclk) begin
		if (!rx_symbol_valid) rx_symbol <= ~rx_symbol;
	end
	// flush answer, prompt or slow as the bench asks
	always @(posedge mclk) begin
		flush_done <= 1'h0;
		if (flush_req && !flush_done) begin
			if (lag_cnt >= flush_lag) begin
				flush_done <= 1'h1;
				lag_cnt <= 4'h0;
			end else begin
				lag_cnt <= lag_cnt + 4'h1;
			end
		end
	end
	// one whole word, check appended; bad flips the last check bit
	task automatic send(input logic [18:0] body, input logic bad);
		rx_symbol = {body, csd_crc_ref(body) ^ (bad ? 5'h01 : 5'h00)};
		rx_symbol_valid = 1'h1;
		@(posedge mclk);
		#1 rx_symbol_valid = 1'h0;
		rx_symbol = ~rx_symbol;
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
 * bench for the codec: encode, decode, reset lockout, status request.
 * assumes csd_peer stands for the far port; status half tied to plain status.
 */
`include "csd_crc_ref.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'h0;
	logic reset = 1'h1;
	logic tx_req_valid = 1'h0, tx_delim_en = 1'h1, tx_abort = 1'h0, port_in_error = 1'h0;
	logic rx_packet_data = 1'h0;
	logic [2:0] tx_delim = 3'h0, tx_modifier = 3'h0;
	logic [4:0] expected_ack_tag = 5'h0B, port_status = 5'h10;
	logic [3:0] flush_lag = 4'h0;
	wire logic tx_req_ready, tx_symbol_valid, flush_req, flush_done, rx_symbol_valid;
	wire logic [23:0] tx_symbol, rx_symbol;
	wire logic rx_sop, rx_eop, rx_cancel, rx_restart_retry, rx_restart_error, rx_mcast;
	wire logic rx_crc_err, rx_reserved, rx_status_valid, dev_reset_req;
	wire logic [2:0] rx_status_code;
	wire logic [4:0] rx_arg_first, rx_arg_second;
	logic [13:0] st_seen = 14'h0000;
	logic [8:0] seen = 9'h000;
	logic [23:0] last_tx = 24'h000000;
	int tx_n = 0, fl_n = 0, cyc = 0, fail_count = 0, checks_done = 0;
	csd_codec u_dut (.mclk, .reset, .tx_req_valid, .tx_req_ready, .tx_status_code(3'h4),
		.tx_arg_first(5'h0A), .tx_arg_second(5'h15), .tx_delim, .tx_modifier, .tx_delim_en,
		.tx_abort, .tx_symbol, .tx_symbol_valid, .flush_req, .flush_done, .expected_ack_tag,
		.port_status, .port_in_error, .rx_symbol, .rx_symbol_valid, .rx_packet_data, .rx_sop,
		.rx_eop, .rx_cancel, .rx_restart_retry, .rx_restart_error, .rx_mcast, .rx_crc_err,
		.rx_reserved, .rx_status_code, .rx_arg_first, .rx_arg_second, .rx_status_valid,
		.dev_reset_req);
	csd_peer u_peer (.mclk, .flush_req, .flush_lag, .flush_done, .rx_symbol, .rx_symbol_valid);
	always #2 mclk = ~mclk;
	// pulses last one cycle, so gather them; also the hang limit
	always @(posedge mclk) begin
		seen <= seen | {rx_sop, rx_eop, rx_cancel, rx_restart_retry, rx_restart_error,
			rx_mcast, rx_crc_err, rx_reserved, dev_reset_req};
		if (tx_symbol_valid) last_tx <= tx_symbol;
		if (rx_status_valid) st_seen <= {1'h1, rx_status_code, rx_arg_first, rx_arg_second};
		if (tx_symbol_valid) tx_n <= tx_n + 1;
		if (flush_req) fl_n <= fl_n + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	function automatic logic [23:0] sym(input logic [2:0] st, input logic [4:0] a,
		input logic [4:0] b, input logic [2:0] dl, input logic [2:0] md);
		return {st, a, b, dl, md, csd_crc_ref({st, a, b, dl, md})};
	endfunction
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one offer held until taken, then the sent word is judged
	task automatic tx(input logic [2:0] dl, input logic [2:0] md, input logic en,
		input logic ab, input logic [23:0] exp);
		int n0;
		n0 = tx_n;
		{tx_delim, tx_modifier, tx_delim_en, tx_abort, tx_req_valid} = {dl, md, en, ab, 1'h1};
		for (int i = 0; i < 50 && tx_req_ready !== 1'h1; i++) @(posedge mclk) #1;
		@(posedge mclk);
		#1 tx_req_valid = 1'h0;
		repeat (2) @(posedge mclk);
		#1 check(last_tx, exp);
		check(24'(tx_n - n0), 24'h000001);
	endtask
	task automatic rx(input logic [2:0] dl, input logic [2:0] md, input logic bad,
		input logic [8:0] exp);
		seen = 9'h000;
		st_seen = 14'h0000;
		u_peer.send({3'h4, 5'h0A, 5'h15, dl, md}, bad);
		repeat (2) @(posedge mclk);
		#1 check({15'h0000, seen}, {15'h0000, exp});
		check({10'h000, st_seen}, bad ? 24'h000000 : {10'h000, 1'h1, 3'h4, 5'h0A, 5'h15});
	endtask
	task automatic tx_scn();
		for (int d = 0; d < 8; d++) tx(3'(d), 3'h3, 1'h1, 1'h0, sym(3'h4, 5'h0A, 5'h15, 3'(d),
			(d == 4) ? 3'h3 : 3'h0));
		tx(3'h0, 3'h3, 1'h0, 1'h0, sym(3'h4, 5'h0A, 5'h15, 3'h7, 3'h0));
		tx(3'h0, 3'h0, 1'h1, 1'h0, sym(3'h4, 5'h0A, 5'h15, 3'h0, 3'h0));
		tx(3'h2, 3'h0, 1'h1, 1'h1, sym(3'h4, 5'h0A, 5'h15, 3'h1, 3'h0));
		tx(3'h2, 3'h0, 1'h1, 1'h1, sym(3'h4, 5'h0A, 5'h15, 3'h2, 3'h0));
	endtask
	// flags: sop eop cancel retry rerr mcast crc rsvd rst
	task automatic rx_scn();
		rx(3'h0, 3'h0, 1'h1, 9'h004);
		rx(3'h0, 3'h0, 1'h0, 9'h100);
		rx(3'h3, 3'h0, 1'h0, 9'h060);
		rx(3'h3, 3'h0, 1'h0, 9'h020);
		rx(3'h0, 3'h0, 1'h0, 9'h100);
		rx(3'h1, 3'h0, 1'h0, 9'h040);
		rx(3'h1, 3'h0, 1'h0, 9'h000);
		rx(3'h0, 3'h0, 1'h0, 9'h100);
		rx(3'h5, 3'h0, 1'h0, 9'h008);
		rx(3'h4, 3'h0, 1'h0, 9'h042);
		rx(3'h6, 3'h0, 1'h0, 9'h002);
		rx(3'h7, 3'h0, 1'h0, 9'h000);
		rx(3'h0, 3'h0, 1'h0, 9'h100);
		rx(3'h2, 3'h0, 1'h0, 9'h080);
	endtask
	task automatic lockout();
		int n0;
		n0 = tx_n;
		repeat (3) rx(3'h4, 3'h3, 1'h0, 9'h000);
		rx_packet_data = 1'h1;
		@(posedge mclk);
		#1 rx_packet_data = 1'h0;
		repeat (3) rx(3'h4, 3'h3, 1'h0, 9'h000);
		rx(3'h7, 3'h0, 1'h0, 9'h000);
		rx(3'h4, 3'h3, 1'h1, 9'h004);
		rx(3'h4, 3'h3, 1'h0, 9'h001);
		check(24'(tx_n - n0), 24'h000000);
	endtask
	task automatic instat(input logic err, input logic [3:0] lag, input logic [8:0] ev);
		int n0;
		int f0;
		{port_in_error, flush_lag, port_status} = {err, lag, err ? 5'h05 : 5'h10};
		n0 = tx_n;
		f0 = fl_n;
		rx(3'h4, 3'h4, 1'h0, ev);
		for (int i = 0; i < 60 && tx_n == n0; i++) @(posedge mclk) #1;
		check(last_tx, sym(3'h6, 5'h0B, port_status, 3'h7, 3'h0));
		check({23'h000000, fl_n > f0 + int'(lag)}, 24'h000001);
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		#1 reset = 1'h0;
		@(posedge mclk) #1;
		tx_scn();
		rx_scn();
		lockout();
		instat(1'h0, 4'h0, 9'h000);
		instat(1'h1, 4'h6, 9'h010);
		stop_test();
	end
endmodule
`default_nettype wire

// ==== rtl/csd_codec.sv ====
/*
 * delimiter/request half codec for 24-bit control symbols plus check value.
 * assumes the transmit and receive paths are on mclk; rx symbols arrive as
 * whole words with a one-cycle valid; the tx side offers one symbol at a time
 * with valid/ready; device reset sequence is driven from dev_reset_req.
 *
 * the caller owns the packet framing on both sides: this block only sees
 * control symbols, plus a pulse for packet data so the reset lockout can
 * tell that something other than a symbol passed between two requests.
 * the output port flush is a handshake toward the caller's ack queue; how
 * it drains (drop or send) is its business, this block only waits for done.
 * dev_reset_req must be wired back into the device reset by the caller; the
 * block does not reset itself, so the confirm pulse is seen in full.
 * expected_ack_tag and port_status are sampled on the cycle the request
 * word is taken, so later changes do not leak into a pending response.
 */
`default_nettype none
`include "csd_consts.svh"
module csd_codec (
	input wire logic mclk, // core clock 250 MHz
	input wire logic reset, // async, high
	// transmit request side
	input wire logic tx_req_valid, // symbol to send
	output logic tx_req_ready, // taken this cycle
	input wire logic [2:0] tx_status_code, // status function code
	input wire logic [4:0] tx_arg_first, // status_arg_first
	input wire logic [4:0] tx_arg_second, // status_arg_second
	input wire logic [2:0] tx_delim, // delimiter code
	input wire logic [2:0] tx_modifier, // modifier
	input wire logic tx_delim_en, // delimiter field meaningful
	input wire logic tx_abort, // abort packet in progress
	output logic [23:0] tx_symbol, // encoded symbol
	output logic tx_symbol_valid, // symbol pulse
	// pending-ack flush hook toward output port
	output logic flush_req, // flush pending control symbols
	input wire logic flush_done, // flush finished
	input wire logic [4:0] expected_ack_tag, // next expected tag
	input wire logic [4:0] port_status, // input port condition
	input wire logic port_in_error, // port in error condition
	// receive side
	input wire logic [23:0] rx_symbol, // received symbol
	input wire logic rx_symbol_valid, // symbol pulse
	input wire logic rx_packet_data, // packet data character seen
	output logic rx_sop, // start of packet
	output logic rx_eop, // end of packet
	output logic rx_cancel, // packet cancelled
	output logic rx_restart_retry, // retransmission begins
	output logic rx_restart_error, // restart-from-error request
	output logic rx_mcast, // multicast event forward
	output logic rx_crc_err, // check mismatch
	output logic rx_reserved, // reserved code or modifier
	output logic [2:0] rx_status_code, // status half passed on
	output logic [4:0] rx_arg_first, // arg pass-through
	output logic [4:0] rx_arg_second, // arg pass-through
	output logic rx_status_valid, // status half valid
	output logic dev_reset_req // confirmed reset, pulse
);
	logic [4:0] tx_chk, rx_chk;
	logic [18:0] tx_cov;
	logic [2:0] tx_dl, tx_md;
	logic rx_ok;
	logic [2:0] rx_dl, rx_md;
	logic in_pkt_r, in_pkt_nxt;
	logic tx_pkt_r, tx_pkt_nxt;
	csd_pkg::csd_tx_state_t st_r, st_nxt;
	logic [4:0] resp_tag_r, resp_tag_nxt, resp_stat_r, resp_stat_nxt;
	logic pend_r, pend_nxt;
	logic [23:0] txs_nxt;
	logic txv_nxt;
	logic sop_n, eop_n, can_n, rr_n, re_n, mc_n, ce_n, rs_n, sv_n;
	logic reset_req_sym, plain_sym, instat_sym;

	// decode helper used by both halves
	function automatic logic is_delim(input logic [2:0] dl, input logic in_pkt);
		case (dl)
			`CSD_DL_SOP, `CSD_DL_CANCEL, `CSD_DL_EOP: is_delim = 1'b1;
			`CSD_DL_RESTART, `CSD_DL_LREQ: is_delim = in_pkt;
			default: is_delim = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// transmit encoding
	// ----------------------------------------
	// abort overrides the offered delimiter only inside an open packet; empty delimiter becomes no-op
	always_comb begin
		tx_dl = tx_delim_en ? tx_delim : `CSD_DL_NOP;
		if (tx_abort && tx_pkt_r) begin
			tx_dl = `CSD_DL_CANCEL;
		end
		tx_md = (tx_dl == `CSD_DL_LREQ) ? tx_modifier : `CSD_MOD_NONE;
	end

	assign tx_cov = (st_r == csd_pkg::csd_tx_resp)
		? {`CSD_ST_LRESP, resp_tag_r, resp_stat_r, `CSD_DL_NOP, `CSD_MOD_NONE}
		: {tx_status_code, tx_arg_first, tx_arg_second, tx_dl, tx_md};

	csd_crc5 u_tx_crc (
		.cov(tx_cov),
		.chk(tx_chk)
	);

	// response takes the slot; user traffic waits while flushing or answering
	assign tx_req_ready = (st_r == csd_pkg::csd_tx_idle);
	assign flush_req = (st_r == csd_pkg::csd_tx_flush);

	// ----------------------------------------
	// receive decode
	// ----------------------------------------
	csd_crc5 u_rx_crc (
		.cov(rx_symbol[`CSD_SYM_W-1:`CSD_COV_LO]),
		.chk(rx_chk)
	);

	assign rx_ok = rx_symbol_valid && (rx_chk == rx_symbol[`CSD_CHK_HI:`CSD_CHK_LO]);
	assign rx_dl = rx_symbol[`CSD_DELIM_HI:`CSD_DELIM_LO];
	assign rx_md = rx_symbol[`CSD_MOD_HI:`CSD_MOD_LO];
	assign reset_req_sym = (rx_dl == `CSD_DL_LREQ) && (rx_md == `CSD_MOD_RESET);
	assign instat_sym = (rx_dl == `CSD_DL_LREQ) && (rx_md == `CSD_MOD_INSTAT);
	assign plain_sym = (rx_dl == `CSD_DL_NOP)
		&& (rx_symbol[`CSD_STAT_HI:`CSD_STAT_LO] == `CSD_ST_STATUS);

	csd_resetlock u_lock (
		.mclk(mclk),
		.reset(reset),
		.sym_ok(rx_ok),
		.is_reset_req(reset_req_sym),
		.is_plain(plain_sym),
		.other_seen(rx_packet_data),
		.fire(dev_reset_req)
	);

	// ----------------------------------------
	// receive events
	// ----------------------------------------
	// receive events; a failed check acts on nothing
	// a bad word raises only the error pulse: acting on a damaged delimiter
	// would open or close packets that the far side never framed.
	// restart and link-request cancel only an open packet; outside one they
	// are plain requests and must not look like a cancel to the caller.
	// the status half is passed on for every good word, whatever the
	// delimiter half holds, so acknowledgements ride along unharmed.
	always_comb begin
		sop_n = 1'b0;
		eop_n = 1'b0;
		can_n = 1'b0;
		rr_n = 1'b0;
		re_n = 1'b0;
		mc_n = 1'b0;
		rs_n = 1'b0;
		ce_n = rx_symbol_valid && !rx_ok;
		sv_n = rx_ok;
		in_pkt_nxt = in_pkt_r;
		if (rx_ok) begin
			case (rx_dl)
				`CSD_DL_SOP: begin
					sop_n = 1'b1;
					in_pkt_nxt = 1'b1;
				end
				`CSD_DL_CANCEL: begin
					can_n = in_pkt_r;
					in_pkt_nxt = 1'b0;
				end
				`CSD_DL_EOP: begin
					eop_n = 1'b1;
					in_pkt_nxt = 1'b0;
				end
				`CSD_DL_RESTART: begin
					can_n = is_delim(rx_dl, in_pkt_r);
					rr_n = 1'b1;
					in_pkt_nxt = 1'b0;
				end
				`CSD_DL_LREQ: begin
					can_n = is_delim(rx_dl, in_pkt_r);
					in_pkt_nxt = 1'b0;
					re_n = instat_sym && port_in_error;
					rs_n = !reset_req_sym && !instat_sym;
				end
				`CSD_DL_MCAST: mc_n = 1'b1;
				`CSD_DL_RSVD: rs_n = 1'b1;
				`CSD_DL_NOP: ;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// input-status response
	// ----------------------------------------
	// capture the input-status request and answer after the flush
	// user traffic keeps priority while idle: a response that jumped ahead
	// could split a packet's delimiters. the cost is that a steady offer
	// delays the answer until the offer pauses for one cycle.
	// a second request during the answer is remembered in pend, so the far
	// side is answered again; one during flush only refreshes the captured tag and status.
	always_comb begin
		st_nxt = st_r;
		pend_nxt = pend_r;
		resp_tag_nxt = resp_tag_r;
		resp_stat_nxt = resp_stat_r;
		txs_nxt = tx_symbol;
		txv_nxt = 1'b0;
		tx_pkt_nxt = tx_pkt_r;
		// reset-device is never answered, only input-status
		if (rx_ok && instat_sym) begin
			pend_nxt = 1'b1;
			resp_tag_nxt = expected_ack_tag;
			resp_stat_nxt = port_status;
		end
		case (st_r)
			csd_pkg::csd_tx_idle: begin
				if (tx_req_valid) begin
					txs_nxt = {tx_cov, tx_chk};
					txv_nxt = 1'b1;
					if (tx_dl == `CSD_DL_SOP) begin
						tx_pkt_nxt = 1'b1;
					end else if (is_delim(tx_dl, tx_pkt_r)) begin
						tx_pkt_nxt = 1'b0;
					end
				end else if (pend_r) begin
					st_nxt = csd_pkg::csd_tx_flush;
				end
			end
			csd_pkg::csd_tx_flush: begin
				if (flush_done) begin
					st_nxt = csd_pkg::csd_tx_resp;
				end
			end
			csd_pkg::csd_tx_resp: begin
				txs_nxt = {tx_cov, tx_chk};
				txv_nxt = 1'b1;
				pend_nxt = rx_ok && instat_sym;
				st_nxt = csd_pkg::csd_tx_idle;
			end
			default: st_nxt = csd_pkg::csd_tx_idle;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// every output of the codec but tx_req_ready and flush_req, which are decoded from st_r,
	// leaves from a flop, so the caller sees clean one-cycle pulses and a word that holds until the next send.
	// the status fields are captured every cycle; they only mean something
	// in the cycle rx_status_valid is high.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= csd_pkg::csd_tx_idle;
			pend_r <= 1'b0;
			resp_tag_r <= 5'h00;
			resp_stat_r <= 5'h00;
			tx_symbol <= 24'h000000;
			tx_symbol_valid <= 1'b0;
			tx_pkt_r <= 1'b0;
			in_pkt_r <= 1'b0;
			rx_sop <= 1'b0;
			rx_eop <= 1'b0;
			rx_cancel <= 1'b0;
			rx_restart_retry <= 1'b0;
			rx_restart_error <= 1'b0;
			rx_mcast <= 1'b0;
			rx_crc_err <= 1'b0;
			rx_reserved <= 1'b0;
			rx_status_code <= 3'h0;
			rx_arg_first <= 5'h00;
			rx_arg_second <= 5'h00;
			rx_status_valid <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pend_r <= pend_nxt;
			resp_tag_r <= resp_tag_nxt;
			resp_stat_r <= resp_stat_nxt;
			tx_symbol <= txs_nxt;
			tx_symbol_valid <= txv_nxt;
			tx_pkt_r <= tx_pkt_nxt;
			in_pkt_r <= in_pkt_nxt;
			rx_sop <= sop_n;
			rx_eop <= eop_n;
			rx_cancel <= can_n;
			rx_restart_retry <= rr_n;
			rx_restart_error <= re_n;
			rx_mcast <= mc_n;
			rx_crc_err <= ce_n;
			rx_reserved <= rs_n;
			rx_status_code <= rx_symbol[`CSD_STAT_HI:`CSD_STAT_LO];
			rx_arg_first <= rx_symbol[`CSD_ARG1_HI:`CSD_ARG1_LO];
			rx_arg_second <= rx_symbol[`CSD_ARG2_HI:`CSD_ARG2_LO];
			rx_status_valid <= sv_n;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/csd_consts.svh ====
/*
 * constants for the delimiter/request control symbol codec: field positions,
 * function codes, modifiers, check preset and lockout count.
 * assumes inclusion by bare name from rtl files; holds definitions only.
 */
`ifndef CSD_CONSTS_SVH
`define CSD_CONSTS_SVH

// ----------------------------------------
// symbol layout, bit 0 is the msb of the word
// ----------------------------------------
`define CSD_SYM_W 24
`define CSD_STAT_HI 23
`define CSD_STAT_LO 21
`define CSD_ARG1_HI 20
`define CSD_ARG1_LO 16
`define CSD_ARG2_HI 15
`define CSD_ARG2_LO 11
`define CSD_DELIM_HI 10
`define CSD_DELIM_LO 8
`define CSD_MOD_HI 7
`define CSD_MOD_LO 5
`define CSD_CHK_HI 4
`define CSD_CHK_LO 0
`define CSD_COV_LO 5

// ----------------------------------------
// codes
// ----------------------------------------
`define CSD_DL_SOP 3'h0
`define CSD_DL_CANCEL 3'h1
`define CSD_DL_EOP 3'h2
`define CSD_DL_RESTART 3'h3
`define CSD_DL_LREQ 3'h4
`define CSD_DL_MCAST 3'h5
`define CSD_DL_RSVD 3'h6
`define CSD_DL_NOP 3'h7
`define CSD_MOD_NONE 3'h0
`define CSD_MOD_RESET 3'h3
`define CSD_MOD_INSTAT 3'h4
`define CSD_ST_STATUS 3'h4
`define CSD_ST_LRESP 3'h6
`define CSD_CHK_PRESET 5'h1F
`define CSD_RESET_COUNT 3'h4
`define CSD_ZERO3 3'h0

`endif

// ==== rtl/csd_crc5.sv ====
/*
 * single-stage parallel check value over symbol bits 0..18.
 * assumes cov[18] is symbol bit 0; preset and trailing zero folded in.
 */
`default_nettype none
module csd_crc5 (
	input wire logic [18:0] cov, // symbol bits 0..18, msb first
	output logic [4:0] chk // c0..c4, c0 in bit 4
);
	logic [18:0] d;

	// ----------------------------------------
	// remap so d[k] is Dk
	// ----------------------------------------
	genvar k;
	generate
		for (k = 0; k < 19; k++) begin : g_map
			assign d[k] = cov[18 - k];
		end
	endgenerate

	// equations: preset ones and zero tail already folded; generator x5+x4+x2+1
	assign chk[0] = d[0]^d[2]^d[3]^d[4]^d[9]^d[11]^d[14]^d[15]^d[17]^d[18];
	assign chk[1] = d[1]^d[2]^d[3]^d[8]^d[10]^d[13]^d[14]^d[16]^d[17]^~d[18];
	assign chk[2] = d[1]^d[3]^d[4]^d[7]^d[11]^d[12]^d[13]^d[14]^d[16]^~d[18];
	assign chk[3] = d[0]^d[2]^d[3]^d[6]^d[10]^d[11]^d[12]^d[13]^d[15]^d[17]^~d[18];
	assign chk[4] = d[0]^d[1]^d[3]^d[4]^d[5]^d[10]^d[12]^d[15]^d[16]^d[18];
endmodule
`default_nettype wire

// ==== rtl/csd_pkg.sv ====
/*
 * types shared by the codec files.
 * assumes csd_consts.svh alongside.
 */
`default_nettype none
package csd_pkg;
	typedef enum logic [1:0] {
		csd_tx_idle,
		csd_tx_flush,
		csd_tx_resp
	} csd_tx_state_t;
endpackage
`default_nettype wire

// ==== rtl/csd_resetlock.sv ====
/*
 * four-in-a-row lockout for reset-device requests.
 * assumes one pulse per received good symbol from the same clock.
 */
`default_nettype none
`include "csd_consts.svh"
module csd_resetlock (
	input wire logic mclk, // core clock
	input wire logic reset, // async, high
	input wire logic sym_ok, // good symbol this cycle
	input wire logic is_reset_req, // symbol is a reset-device request
	input wire logic is_plain, // plain status, no delimiter function
	input wire logic other_seen, // packet data seen between symbols
	output logic fire // one-cycle reset confirm
);
	logic [2:0] cnt_r, cnt_nxt;
	logic fire_nxt;

	// ----------------------------------------
	// counting; plain status and failed-check words leave the run alone, a request counts even with packet data in its cycle, anything else breaks it
	// ----------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		fire_nxt = 1'b0;
		if (other_seen) begin
			cnt_nxt = `CSD_ZERO3;
		end
		if (sym_ok) begin
			if (is_reset_req) begin
				if (cnt_r + 3'h1 == `CSD_RESET_COUNT) begin
					fire_nxt = 1'b1;
					cnt_nxt = `CSD_ZERO3;
				end else begin
					cnt_nxt = cnt_r + 3'h1;
				end
			end else if (!is_plain) begin
				cnt_nxt = `CSD_ZERO3;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_r <= `CSD_ZERO3;
			fire <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			fire <= fire_nxt;
		end
	end
endmodule
`default_nettype wire
